// ==== verilog/sdx_cfg.svh ====
`ifndef SDX_CFG_SVH
`define SDX_CFG_SVH
`define SDX_F_OPC 6:0
`define SDX_F_IND 7
`define SDX_F_QUAD 8
`define SDX_F_IGNORE_CHANNEL_MASKS 9
`define SDX_F_PRED 11:10
`define SDX_F_PINV 12
`define SDX_F_ESZ 15:13
`define SDX_F_ACCWR 16
`define SDX_F_FSUB 18:17
`define SDX_F_SAT 19
`define SDX_F_CMOD 23:20
`define SDX_F_DCE 27:24
`define SDX_F_CMPT 29
`define SDX_F_DEP 31:30
`define SDX_F_DRF 33:32
`define SDX_F_DTY 36:34
`define SDX_F_S0RF 38:37
`define SDX_F_S0TY 41:39
`define SDX_F_S1RF 43:42
`define SDX_F_S1TY 46:44
`define SDX_F_DREG 53:47
`define SDX_F_DSUB 58:54
`define SDX_F_S0MOD 60:59
`define SDX_F_S0REG 70:64
`define SDX_F_S0SUB 75:71
`define SDX_F_SWZ 83:76
`define SDX_F_S1REG 102:96
`define SDX_F_S1SUB 107:103
`define SDX_F_IMM 127:96
`define SDX_F_LO 31:0
`define SDX_C_DREG 38:32
`define SDX_C_S0REG 45:39
`define SDX_C_S1REG 52:46
`define SDX_C_TY 55:53
`define SDX_OP_MOV 7'h01
`define SDX_OP_NOT 7'h04
`define SDX_OP_JMP 7'h20
`define SDX_OP_SEND 7'h31
`define SDX_OP_MUL 7'h41
`define SDX_OP_DP4 7'h54
`define SDX_OP_LINE 7'h59
`define SDX_OP_PLN 7'h5A
`define SDX_NULL_REG 7'h00
`define SDX_IP_REG 7'h10
`define SDX_SWZ_ID 8'hE4
`define SDX_LEN_NATIVE 16
`define SDX_LEN_COMPACT 8
`define SDX_A_CTRL 8'h00
`define SDX_A_EXECUTION_MASK 8'h04
`define SDX_A_FLAG0 8'h08
`define SDX_A_FLAG1 8'h0C
`define SDX_A_KLIMIT 8'h10
`define SDX_A_IP 8'h14
`define SDX_A_STATUS 8'h18
`define SDX_CTRL_SPF 0
`define SDX_CTRL_ACCDIS 1
`define SDX_FP_ONE 32'h3F80_0000
`define SDX_CM_NONE 4'h0
`define SDX_CM_E 4'h1
`define SDX_CM_NE 4'h2
`define SDX_CM_G 4'h3
`define SDX_CM_GE 4'h4
`define SDX_CM_L 4'h5
`define SDX_CM_LE 4'h6
`endif

// ==== verilog/sdx_pkg.sv ====
package sdx_pkg;
  typedef enum logic [1:0] {
    SDX_RF_ARF, SDX_RF_GRF, SDX_RF_IMM, SDX_RF_MEM
  } sdx_rf_e;
  typedef enum logic [2:0] {
    SDX_T_UD, SDX_T_D, SDX_T_UW, SDX_T_W,
    SDX_T_UB, SDX_T_B, SDX_T_DF, SDX_T_F
  } sdx_type_e;
  typedef enum logic [1:0] {
    SDX_SM_NONE, SDX_SM_NEG, SDX_SM_ABS, SDX_SM_NABS
  } sdx_smod_e;
  typedef enum logic [1:0] {
    SDX_PR_NONE, SDX_PR_SEQ, SDX_PR_ANY4, SDX_PR_ALL4
  } sdx_pred_e;
endpackage : sdx_pkg

// ==== verilog/sdx_issue_decode.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "sdx_cfg.svh"
// Functional notes
// - Single-source ops: src1 null, src0 type.
// - Immediate src0 from fourth dword, src1 ARCHITECTURE_REG_FILE.
// - Prefetched words past kernel end never execute.
// - Accept 128-bit native and 64-bit compact words.
// - One or two sources; only last immediate.
// - 128 general registers of 32 bytes.
// - Dst and src0 subregister offsets aligned to element size.
// - No data instruction touches system memory.
// - Architecture registers never as src1 of a two-source op.
// - Channel runs when its pointer matches thread.
// - Branches use signed offsets; mov to ip.
// - Predicate mask from flags, control and invert.
// - Five masking factors gate each channel.
// - Regions: byte or quad aligned, direct/indirect.
// - Quad mode swizzles channels within groups.
// - Convert source to execution type first.
// - Source modifier follows conversion, precedes op.
// - Saturation clamps float unit, integer type range; DF results pass through unclamped.
// - Accumulator write gated by disable flag.
// - Condition modifier writes selected flag subregister.
module sdx_issue_decode
  import sdx_pkg::*;
#(
  parameter int NCH = 16,
  parameter int AW = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic inst_valid_i,
  input wire logic [127:0] inst_i,
  input wire logic [AW-1:0] inst_addr_i,
  input wire logic res_valid_i,
  input wire logic [31:0] res_data_i,
  input wire logic [NCH-1:0] res_zero_i,
  input wire logic [NCH-1:0] res_sign_i,
  output logic [AW-1:0] fetch_addr_o,
  output logic issue_valid_o,
  output logic issue_err_o,
  output logic [6:0] issue_opcode_o,
  output logic [NCH-1:0] issue_chan_en_o,
  output logic issue_quad_o,
  output logic issue_indirect_o,
  output logic [11:0] issue_dst_o,
  output logic [11:0] issue_src0_o,
  output logic [11:0] issue_src1_o,
  output logic [31:0] issue_imm_o,
  output logic issue_imm_vld_o,
  output logic [NCH*4-1:0] issue_swz_o,
  output logic issue_sat_o,
  output logic issue_acc_wr_o,
  output logic [1:0] issue_dep_o,
  output logic wb_valid_o,
  output logic [31:0] wb_data_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  function automatic logic [127:0] expand(input logic [63:0] c);
    logic [127:0] e;
    e = '0;
    e[`SDX_F_LO] = c[`SDX_F_LO];
    e[`SDX_F_CMPT] = 1'b0;
    e[`SDX_F_DRF] = SDX_RF_GRF;
    e[`SDX_F_S0RF] = SDX_RF_GRF;
    e[`SDX_F_S1RF] = SDX_RF_GRF;
    e[`SDX_F_DTY] = c[`SDX_C_TY];
    e[`SDX_F_S0TY] = c[`SDX_C_TY];
    e[`SDX_F_S1TY] = c[`SDX_C_TY];
    e[`SDX_F_DREG] = c[`SDX_C_DREG];
    e[`SDX_F_S0REG] = c[`SDX_C_S0REG];
    e[`SDX_F_S1REG] = c[`SDX_C_S1REG];
    e[`SDX_F_SWZ] = `SDX_SWZ_ID;
    return e;
  endfunction : expand

  function automatic logic [1:0] nsrc_f(input logic [6:0] op);
    case (op)
      `SDX_OP_MOV, `SDX_OP_NOT, `SDX_OP_JMP: nsrc_f = 2'd1;
      default: nsrc_f = 2'd2;
    endcase
  endfunction : nsrc_f

  // Element size as a mask of the low subregister bits.
  function automatic logic [4:0] amask_f(input logic [2:0] t);
    case (sdx_type_e'(t))
      SDX_T_UD, SDX_T_D, SDX_T_F: amask_f = 5'h03;
      SDX_T_UW, SDX_T_W: amask_f = 5'h01;
      SDX_T_DF: amask_f = 5'h07;
      default: amask_f = 5'h00;
    endcase
  endfunction : amask_f

  function automatic logic [31:0] conv_f(input logic [2:0] t,
                                         input logic [31:0] v);
    case (sdx_type_e'(t))
      SDX_T_UW: conv_f = {16'h0000, v[15:0]};
      SDX_T_W: conv_f = {{16{v[15]}}, v[15:0]};
      SDX_T_UB: conv_f = {24'h00_0000, v[7:0]};
      SDX_T_B: conv_f = {{24{v[7]}}, v[7:0]};
      default: conv_f = v;
    endcase
  endfunction : conv_f

  function automatic logic [31:0] smod_f(input logic [1:0] m,
                                         input logic fp,
                                         input logic [31:0] v);
    logic [31:0] a;
    a = fp ? {1'b0, v[30:0]} : (v[31] ? -v : v);
    case (sdx_smod_e'(m))
      SDX_SM_NEG: smod_f = fp ? {~v[31], v[30:0]} : -v;
      SDX_SM_ABS: smod_f = a;
      SDX_SM_NABS: smod_f = fp ? {1'b1, a[30:0]} : -a;
      default: smod_f = v;
    endcase
  endfunction : smod_f

  function automatic logic [NCH*4-1:0] swz_f(input logic [7:0] s,
                                             input logic q);
    logic [NCH*4-1:0] m;
    logic [1:0] k;
    m = '0;
    for (int n = 0; n < NCH; n++) begin
      k = q ? s[(n%4)*2 +: 2] : 2'(n % 4);
      m[n*4 +: 4] = 4'((n / 4) * 4) + {2'b00, k};
    end
    return m;
  endfunction : swz_f

  function automatic logic [31:0] sat_f(input logic [2:0] t,
                                        input logic [31:0] v);
    logic s;
    s = v[31];
    case (sdx_type_e'(t))
      SDX_T_F: sat_f = s ? 32'h0000_0000 :
        (v > `SDX_FP_ONE ? `SDX_FP_ONE : v);
      SDX_T_UW: sat_f = s ? 32'h0000_0000 :
        (v > 32'h0000_FFFF ? 32'h0000_FFFF : v);
      SDX_T_W: sat_f = ($signed(v) > 32'sh0000_7FFF) ? 32'h0000_7FFF :
        (($signed(v) < -32'sh0000_8000) ? 32'hFFFF_8000 : v);
      SDX_T_UB: sat_f = s ? 32'h0000_0000 :
        (v > 32'h0000_00FF ? 32'h0000_00FF : v);
      SDX_T_B: sat_f = ($signed(v) > 32'sh0000_007F) ? 32'h0000_007F :
        (($signed(v) < -32'sh0000_0080) ? 32'hFFFF_FF80 : v);
      SDX_T_UD: sat_f = s ? 32'h0000_0000 : v;
      default: sat_f = v;
    endcase
  endfunction : sat_f

  logic ctrl_spf_r;
  logic acc_dis_r;
  logic [NCH-1:0] execution_mask_r;
  logic [NCH-1:0] flag_r [4];
  logic [AW-1:0] klimit_r;
  logic [AW-1:0] ip_r;
  logic [AW-1:0] per_channel_ip_r [NCH];
  logic [15:0] err_cnt_r;
  logic [15:0] drop_cnt_r;
  logic [3:0] lat_cmod_r;
  logic [1:0] lat_fsel_r;
  logic [2:0] lat_dty_r;
  logic lat_sat_r;
  logic [NCH-1:0] lat_en_r;

  logic [127:0] nw;
  logic [6:0] opc;
  logic [1:0] nsrc;
  logic past_end;
  logic bad;
  logic accept;
  logic is_send;
  logic long_op;
  logic branch;
  logic [AW-1:0] nxt_ip;
  logic [AW-1:0] target;
  logic [4:0] esz;
  logic [NCH-1:0] pflag;
  logic [NCH-1:0] onip;
  logic [NCH-1:0] pmask;
  logic [NCH-1:0] chan_en;
  logic [31:0] imm_x;
  logic s0_imm;
  logic [3:0] dce;

  assign nw = inst_i[`SDX_F_CMPT] ? expand(inst_i[63:0]) : inst_i;
  assign opc = nw[`SDX_F_OPC];
  assign nsrc = nsrc_f(opc);
  assign s0_imm = nw[`SDX_F_S0RF] == SDX_RF_IMM;
  assign past_end = inst_addr_i >= klimit_r;
  assign is_send = opc == `SDX_OP_SEND;
  assign long_op = opc == `SDX_OP_PLN || opc == `SDX_OP_LINE ||
    opc == `SDX_OP_DP4 || nw[`SDX_F_DTY] == SDX_T_DF ||
    nw[`SDX_F_S0TY] == SDX_T_DF ||
    (opc == `SDX_OP_MUL && nw[`SDX_F_S0TY] inside {SDX_T_D, SDX_T_UD} &&
     nw[`SDX_F_S1TY] inside {SDX_T_D, SDX_T_UD});

  // Malformed words are dropped rather than issued with garbage operands.
  always_comb begin
    bad = 1'b0;
    if (nw[`SDX_F_DRF] inside {SDX_RF_IMM, SDX_RF_MEM} ||
        nw[`SDX_F_S0RF] == SDX_RF_MEM || nw[`SDX_F_S1RF] == SDX_RF_MEM)
      bad = 1'b1;
    if (nsrc == 2'd1 && !s0_imm &&
        (nw[`SDX_F_S1RF] != SDX_RF_ARF ||
         nw[`SDX_F_S1REG] != `SDX_NULL_REG ||
         nw[`SDX_F_S1TY] != nw[`SDX_F_S0TY]))
      bad = 1'b1;
    if (s0_imm && (nsrc != 2'd1 || nw[`SDX_F_S1RF] != SDX_RF_ARF ||
        nw[`SDX_F_S1TY] != nw[`SDX_F_S0TY]))
      bad = 1'b1;
    if (nsrc == 2'd2 && nw[`SDX_F_S1RF] == SDX_RF_ARF)
      bad = 1'b1;
    if ((nw[`SDX_F_DSUB] & amask_f(nw[`SDX_F_DTY])) != 5'h00 ||
        (!s0_imm &&
         (nw[`SDX_F_S0SUB] & amask_f(nw[`SDX_F_S0TY])) != 5'h00))
      bad = 1'b1;
  end

  assign accept = inst_valid_i && !past_end && !bad;
  assign nxt_ip = inst_addr_i + (inst_i[`SDX_F_CMPT] ?
    AW'(`SDX_LEN_COMPACT) : AW'(`SDX_LEN_NATIVE));
  assign imm_x = conv_f(nw[`SDX_F_S0TY], nw[`SDX_F_IMM]);
  assign branch = opc == `SDX_OP_JMP || (opc == `SDX_OP_MOV &&
    nw[`SDX_F_DRF] == SDX_RF_ARF && nw[`SDX_F_DREG] == `SDX_IP_REG);
  assign target = (opc == `SDX_OP_JMP) ?
    inst_addr_i + imm_x[AW-1:0] : imm_x[AW-1:0];
  assign esz = 5'd1 << nw[`SDX_F_ESZ];
  assign pflag = flag_r[nw[`SDX_F_FSUB]];
  assign dce = nw[`SDX_F_DCE];

  always_comb begin
    for (int n = 0; n < NCH; n++) begin
      onip[n] = ctrl_spf_r || nw[`SDX_F_IGNORE_CHANNEL_MASKS] ||
        per_channel_ip_r[n] == inst_addr_i;
      case (sdx_pred_e'(nw[`SDX_F_PRED]))
        SDX_PR_SEQ: pmask[n] = pflag[n] ^ nw[`SDX_F_PINV];
        SDX_PR_ANY4: pmask[n] = |pflag[(n/4)*4 +: 4] ^ nw[`SDX_F_PINV];
        SDX_PR_ALL4: pmask[n] = &pflag[(n/4)*4 +: 4] ^ nw[`SDX_F_PINV];
        default: pmask[n] = 1'b1;
      endcase
      chan_en[n] = (5'(n) < esz) && execution_mask_r[n] && onip[n] &&
        pmask[n] && (!nw[`SDX_F_QUAD] || nw[`SDX_F_IGNORE_CHANNEL_MASKS] ||
        dce[n % 4]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      issue_valid_o <= 1'b0;
      issue_err_o <= 1'b0;
      issue_opcode_o <= '0;
      issue_chan_en_o <= '0;
      issue_quad_o <= 1'b0;
      issue_indirect_o <= 1'b0;
      issue_dst_o <= '0;
      issue_src0_o <= '0;
      issue_src1_o <= '0;
      issue_imm_o <= '0;
      issue_imm_vld_o <= 1'b0;
      issue_swz_o <= '0;
      issue_sat_o <= 1'b0;
      issue_acc_wr_o <= 1'b0;
      issue_dep_o <= '0;
    end else begin
      issue_valid_o <= accept;
      issue_err_o <= inst_valid_i && !past_end && bad;
      if (accept) begin
        issue_opcode_o <= opc;
        issue_chan_en_o <= chan_en;
        issue_quad_o <= nw[`SDX_F_QUAD];
        issue_indirect_o <= nw[`SDX_F_IND];
        issue_dst_o <= {nw[`SDX_F_DREG], nw[`SDX_F_DSUB]};
        issue_src0_o <= {nw[`SDX_F_S0REG], nw[`SDX_F_S0SUB]};
        issue_src1_o <= {nw[`SDX_F_S1REG], nw[`SDX_F_S1SUB]};
        issue_imm_o <= smod_f(nw[`SDX_F_S0MOD],
          nw[`SDX_F_S0TY] inside {SDX_T_F, SDX_T_DF}, imm_x);
        issue_imm_vld_o <= s0_imm || nw[`SDX_F_S1RF] == SDX_RF_IMM;
        issue_swz_o <= swz_f(nw[`SDX_F_SWZ], nw[`SDX_F_QUAD]);
        issue_sat_o <= nw[`SDX_F_SAT];
        issue_acc_wr_o <= nw[`SDX_F_ACCWR] && !acc_dis_r;
        issue_dep_o <= (is_send || long_op) ? 2'b00 : nw[`SDX_F_DEP];
      end
    end
  end

  // Result side context; only one instruction is in flight at a time.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lat_cmod_r <= `SDX_CM_NONE;
      lat_fsel_r <= '0;
      lat_dty_r <= '0;
      lat_sat_r <= 1'b0;
      lat_en_r <= '0;
      wb_valid_o <= 1'b0;
      wb_data_o <= '0;
    end else begin
      if (accept) begin
        lat_cmod_r <= nw[`SDX_F_CMOD];
        lat_fsel_r <= nw[`SDX_F_FSUB];
        lat_dty_r <= nw[`SDX_F_DTY];
        lat_sat_r <= nw[`SDX_F_SAT];
        lat_en_r <= chan_en;
      end
      wb_valid_o <= res_valid_i;
      if (res_valid_i)
        wb_data_o <= lat_sat_r ? sat_f(lat_dty_r, res_data_i) :
          res_data_i;
    end
  end

  // Pointer update keeps diverged channels parked until ip returns.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ip_r <= '0;
      for (int n = 0; n < NCH; n++)
        per_channel_ip_r[n] <= '0;
    end else if (wr_i && addr_i == `SDX_A_IP) begin
      ip_r <= wdata_i[AW-1:0];
      for (int n = 0; n < NCH; n++)
        per_channel_ip_r[n] <= wdata_i[AW-1:0];
    end else if (accept) begin
      ip_r <= (branch && |chan_en) ? target : nxt_ip;
      for (int n = 0; n < NCH; n++)
        if (ctrl_spf_r)
          per_channel_ip_r[n] <= (branch && |chan_en) ? target : nxt_ip;
        else if (per_channel_ip_r[n] == inst_addr_i)
          per_channel_ip_r[n] <= (branch && chan_en[n]) ? target : nxt_ip;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_spf_r <= 1'b0;
      acc_dis_r <= 1'b0;
      execution_mask_r <= '1;
      klimit_r <= '1;
    end else if (wr_i) begin
      case (addr_i)
        `SDX_A_CTRL: begin
          ctrl_spf_r <= wdata_i[`SDX_CTRL_SPF];
          acc_dis_r <= wdata_i[`SDX_CTRL_ACCDIS];
        end
        `SDX_A_EXECUTION_MASK: execution_mask_r <= wdata_i[NCH-1:0];
        `SDX_A_KLIMIT: klimit_r <= wdata_i[AW-1:0];
        default: ;
      endcase
    end
  end

  // A result arriving with a bus write to the same flags wins the cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 4; i++)
        flag_r[i] <= '0;
    end else begin
      if (wr_i && addr_i == `SDX_A_FLAG0) begin
        flag_r[0] <= wdata_i[NCH-1:0];
        flag_r[1] <= wdata_i[2*NCH-1:NCH];
      end
      if (wr_i && addr_i == `SDX_A_FLAG1) begin
        flag_r[2] <= wdata_i[NCH-1:0];
        flag_r[3] <= wdata_i[2*NCH-1:NCH];
      end
      if (res_valid_i && lat_cmod_r != `SDX_CM_NONE)
        for (int n = 0; n < NCH; n++)
          if (lat_en_r[n])
            case (lat_cmod_r)
              `SDX_CM_E: flag_r[lat_fsel_r][n] <= res_zero_i[n];
              `SDX_CM_NE: flag_r[lat_fsel_r][n] <= !res_zero_i[n];
              `SDX_CM_G: flag_r[lat_fsel_r][n] <=
                !res_sign_i[n] && !res_zero_i[n];
              `SDX_CM_GE: flag_r[lat_fsel_r][n] <=
                !res_sign_i[n] || res_zero_i[n];
              `SDX_CM_L: flag_r[lat_fsel_r][n] <=
                res_sign_i[n] && !res_zero_i[n];
              `SDX_CM_LE: flag_r[lat_fsel_r][n] <=
                res_sign_i[n] || res_zero_i[n];
              default: ;
            endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_cnt_r <= '0;
      drop_cnt_r <= '0;
    end else begin
      if (inst_valid_i && past_end)
        drop_cnt_r <= drop_cnt_r + 16'h0001;
      if (inst_valid_i && !past_end && bad)
        err_cnt_r <= err_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
      fetch_addr_o <= '0;
    end else begin
      fetch_addr_o <= ip_r;
      rdata_o <= '0;
      if (rd_i)
        case (addr_i)
          `SDX_A_CTRL: rdata_o <= {30'h0000_0000, acc_dis_r, ctrl_spf_r};
          `SDX_A_EXECUTION_MASK: rdata_o <= 32'(execution_mask_r);
          `SDX_A_FLAG0: rdata_o <= 32'({flag_r[1], flag_r[0]});
          `SDX_A_FLAG1: rdata_o <= 32'({flag_r[3], flag_r[2]});
          `SDX_A_KLIMIT: rdata_o <= 32'(klimit_r);
          `SDX_A_IP: rdata_o <= 32'(ip_r);
          `SDX_A_STATUS: rdata_o <= {drop_cnt_r, err_cnt_r};
          default: rdata_o <= '0;
        endcase
    end
  end

  a_past_end_drop: assert property (
    inst_valid_i && past_end |=> !issue_valid_o && !issue_err_o)
    else $error("word past kernel end was issued");
  a_bad_word_held: assert property (
    inst_valid_i && !past_end && bad |=> issue_err_o && !issue_valid_o)
    else $error("malformed word not refused");
  a_acc_disable: assert property (
    acc_dis_r && accept |=> !issue_acc_wr_o)
    else $error("accumulator write while disabled");
  a_exec_size_cap: assert property (
    accept |=> (issue_chan_en_o >> $past(esz)) == '0)
    else $error("channel above execution size enabled");
  a_sat_float_unit: assert property (
    res_valid_i && lat_sat_r && lat_dty_r == SDX_T_F
    |=> wb_data_o <= `SDX_FP_ONE && !wb_data_o[31])
    else $error("float saturation out of unit range");
  a_dep_on_send: assert property (
    accept && (is_send || long_op) |=> issue_dep_o == 2'b00)
    else $error("dependency override leaked");
  a_swz_byte_mode: assert property (
    issue_valid_o && !issue_quad_o
    |-> issue_swz_o == swz_f(`SDX_SWZ_ID, 1'b0))
    else $error("swizzle outside quad mode");
  a_branch_fetch: assert property (
    accept && branch && |chan_en && !wr_i
    |=> ##1 fetch_addr_o == $past(target, 2))
    else $error("branch target not fetched");
endmodule : sdx_issue_decode
`default_nettype wire

// ==== verification/sdx_kernel_mem.sv ====
`timescale 1ns/10ps
`default_nettype none
module sdx_kernel_mem #(
  parameter int AW = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fetch_req_i,
  input wire logic [AW-1:0] fetch_addr_i,
  output logic inst_valid_o,
  output logic [127:0] inst_o,
  output logic [AW-1:0] inst_addr_o
);
  logic [127:0] mem_r [0:63];
  // Every word past a kernel holds null-operand padding.
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem_r[i] = 128'h0;
    end
  end
  // Between words the lines show the inverse of the last value, since an
  // idle line that kept its value would hide a decoder that samples late.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      inst_valid_o <= 1'b0;
      inst_o <= 128'h0;
      inst_addr_o <= '0;
    end else if (fetch_req_i) begin
      inst_valid_o <= 1'b1;
      inst_o <= mem_r[fetch_addr_i[9:4]];
      inst_addr_o <= fetch_addr_i;
    end else begin
      inst_valid_o <= 1'b0;
      inst_o <= ~inst_o;
      inst_addr_o <= ~inst_addr_o;
    end
  end
endmodule : sdx_kernel_mem
`default_nettype wire

// ==== verification/sdx_issue_decode_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "sdx_cfg.svh"
module sdx_issue_decode_tb
  import sdx_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic req = 1'b0;
  logic [15:0] fa = 16'h0000;
  logic rv = 1'b0;
  logic [31:0] rdat = 32'h0000_0000;
  logic [15:0] rz = 16'h0000;
  logic iv, ov, oe, oq, oin, ivl, os, oa, wv;
  logic [127:0] iw, w;
  logic [15:0] ia, fo, ch;
  logic [31:0] rdata, imm, wbd, v;
  logic [6:0] opc;
  logic [11:0] dst, s0, s1;
  logic [63:0] swz;
  logic [1:0] dep;
  logic [1:0] pt [4] = '{2'h1, 2'h1, 2'h2, 2'h3};
  logic [15:0] pe [4] = '{16'h001F, 16'h00E0, 16'h00FF, 16'h000F};
  logic [6:0] dop [4] = '{`SDX_OP_MOV, `SDX_OP_PLN, `SDX_OP_DP4, `SDX_OP_MUL};
  sdx_type_e sty [3] = '{SDX_T_UW, SDX_T_F, SDX_T_F};
  logic [31:0] sd [3] = '{32'h0001_2345, 32'h4000_0000, 32'hBF80_0000};
  logic [31:0] se [3] = '{32'h0000_FFFF, 32'h3F80_0000, 32'h0000_0000};
  int failures = 0;
  int n_compared = 0;
  bit set_ip = 1'b1;
  always #20 clk_i = ~clk_i;
  sdx_kernel_mem #(.AW(16)) km (.clk_i(clk_i), .rst_i(rst_i),
    .fetch_req_i(req), .fetch_addr_i(fa), .inst_valid_o(iv),
    .inst_o(iw), .inst_addr_o(ia));
  sdx_issue_decode #(.NCH(16), .AW(16)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .addr_i(addr), .wdata_i(wdat), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .inst_valid_i(iv), .inst_i(iw), .inst_addr_i(ia), .res_valid_i(rv),
    .res_data_i(rdat), .res_zero_i(rz), .res_sign_i(16'h0000),
    .fetch_addr_o(fo), .issue_valid_o(ov), .issue_err_o(oe),
    .issue_opcode_o(opc), .issue_chan_en_o(ch), .issue_quad_o(oq),
    .issue_indirect_o(oin), .issue_dst_o(dst), .issue_src0_o(s0),
    .issue_src1_o(s1), .issue_imm_o(imm), .issue_imm_vld_o(ivl),
    .issue_swz_o(swz), .issue_sat_o(os), .issue_acc_wr_o(oa),
    .issue_dep_o(dep), .wb_valid_o(wv), .wb_data_o(wbd));
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rreg
  task automatic issue(input logic [127:0] x, input logic [15:0] a);
    km.mem_r[a[9:4]] = x;
    // Parking every channel on the word keeps earlier jumps from masking it.
    if (set_ip) wreg(`SDX_A_IP, {16'h0000, a});
    @(posedge clk_i);
    req <= 1'b1;
    fa <= a;
    @(posedge clk_i);
    req <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask : issue
  task automatic result(input logic [31:0] d, input logic [15:0] z);
    @(posedge clk_i);
    rv <= 1'b1;
    rdat <= d;
    rz <= z;
    @(posedge clk_i);
    rv <= 1'b0;
    #1;
  endtask : result
  task automatic ck(input logic [1:0] ve, input logic [15:0] c);
    chk("valid_err", {30'h0, ve}, {30'h0, ov, oe});
    if (ve == 2'b10) chk("chan_en", {16'h0, c}, {16'h0, ch});
  endtask : ck
  function automatic logic [127:0] base();
    logic [127:0] x;
    // Source 1 stays a null architecture register of the source 0 type.
    x = 128'h0;
    x[`SDX_F_OPC] = `SDX_OP_MOV;
    x[`SDX_F_ESZ] = 3'h3;
    x[`SDX_F_DRF] = SDX_RF_GRF;
    x[`SDX_F_DREG] = 7'h01;
    x[`SDX_F_S0RF] = SDX_RF_GRF;
    x[`SDX_F_S0REG] = 7'h02;
    x[`SDX_F_SWZ] = `SDX_SWZ_ID;
    return x;
  endfunction : base
  function automatic logic [127:0] bad(input int i);
    logic [127:0] x;
    x = base();
    case (i)
      0: begin
        x[`SDX_F_S0RF] = SDX_RF_IMM;
        x[`SDX_F_S1RF] = SDX_RF_GRF;
      end
      1: begin
        x[`SDX_F_OPC] = `SDX_OP_NOT;
        x[`SDX_F_S1RF] = SDX_RF_GRF;
      end
      2: begin
        x[`SDX_F_OPC] = `SDX_OP_MUL;
        x[`SDX_F_S1REG] = `SDX_IP_REG;
      end
      3: begin
        x[`SDX_F_OPC] = `SDX_OP_MUL;
        x[`SDX_F_S0RF] = SDX_RF_IMM;
        x[`SDX_F_S1RF] = SDX_RF_GRF;
      end
      4: x[`SDX_F_DRF] = SDX_RF_MEM;
      5: x[`SDX_F_DSUB] = 5'h02;
      default: x[`SDX_F_S1TY] = SDX_T_W;
    endcase
    return x;
  endfunction : bad
  initial begin
    repeat (4000) @(posedge clk_i);
    failures++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rreg(`SDX_A_EXECUTION_MASK, v);
    chk("execution_mask", 32'h0000_FFFF, v);
    rreg(`SDX_A_KLIMIT, v);
    chk("limit", 32'h0000_FFFF, v);
    wreg(8'h44, 32'h0000_5A5A);
    rreg(8'h44, v);
    chk("unmapped", 32'h0000_0000, v);
    wreg(`SDX_A_FLAG1, 32'h1234_5678);
    rreg(`SDX_A_FLAG1, v);
    chk("flag1", 32'h1234_5678, v);
    $display("test registers finished");
    for (int i = 0; i < 5; i++) begin
      w = base();
      w[`SDX_F_ESZ] = i[2:0];
      issue(w, 16'h0000);
      ck(2'b10, 16'((32'h0000_0001 << (1 << i)) - 1));
    end
    chk("dst", 32'h0000_0020, {20'h0, dst});
    chk("swizzle", 32'h7654_3210, swz[31:0]);
    wreg(`SDX_A_EXECUTION_MASK, 32'h0000_00F0);
    issue(base(), 16'h0000);
    ck(2'b10, 16'h00F0);
    wreg(`SDX_A_EXECUTION_MASK, 32'h0000_FFFF);
    w = base();
    w[`SDX_F_QUAD] = 1'b1;
    w[`SDX_F_DCE] = 4'h5;
    w[`SDX_F_SWZ] = 8'h1B;
    w[`SDX_F_IND] = 1'b1;
    issue(w, 16'h0000);
    ck(2'b10, 16'h0055);
    chk("swizzle", 32'h4567_0123, swz[31:0]);
    chk("quad", 32'h0000_0003, {30'h0, oq, oin});
    w[`SDX_F_IGNORE_CHANNEL_MASKS] = 1'b1;
    issue(w, 16'h0000);
    ck(2'b10, 16'h00FF);
    wreg(`SDX_A_FLAG0, 32'h0000_001F);
    for (int i = 0; i < 4; i++) begin
      w = base();
      w[`SDX_F_PRED] = pt[i];
      w[`SDX_F_PINV] = (i == 1);
      issue(w, 16'h0000);
      ck(2'b10, pe[i]);
    end
    wreg(`SDX_A_FLAG0, 32'h0000_0000);
    $display("test masking finished");
    w = base();
    w[`SDX_F_S0RF] = SDX_RF_IMM;
    w[`SDX_F_DTY] = SDX_T_D;
    w[`SDX_F_S0TY] = SDX_T_D;
    w[`SDX_F_S1TY] = SDX_T_D;
    w[`SDX_F_IMM] = 32'h0000_0005;
    w[`SDX_F_S0MOD] = SDX_SM_NEG;
    issue(w, 16'h0000);
    chk("imm", 32'hFFFF_FFFB, imm);
    chk("imm_vld", 32'h0000_0001, {31'h0, ivl});
    w[`SDX_F_IMM] = 32'hFFFF_FFFB;
    w[`SDX_F_S0MOD] = SDX_SM_ABS;
    issue(w, 16'h0000);
    chk("imm", 32'h0000_0005, imm);
    for (int i = 0; i < 7; i++) begin
      issue(bad(i), 16'h0000);
      ck(2'b01, 16'h0000);
    end
    for (int i = 0; i < 4; i++) begin
      w = base();
      w[`SDX_F_OPC] = dop[i];
      w[`SDX_F_DEP] = 2'h3;
      if (i > 0) w[`SDX_F_S1RF] = SDX_RF_GRF;
      issue(w, 16'h0000);
      chk("dep", (i == 0) ? 32'h0000_0003 : 32'h0000_0000, {30'h0, dep});
    end
    $display("test operands finished");
    w = base();
    w[`SDX_F_ACCWR] = 1'b1;
    issue(w, 16'h0000);
    chk("acc_wr", 32'h0000_0001, {31'h0, oa});
    wreg(`SDX_A_CTRL, 32'h0000_0002);
    issue(w, 16'h0000);
    chk("acc_wr", 32'h0000_0000, {31'h0, oa});
    wreg(`SDX_A_CTRL, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      w = base();
      w[`SDX_F_SAT] = 1'b1;
      w[`SDX_F_DTY] = sty[i];
      w[`SDX_F_S0TY] = sty[i];
      w[`SDX_F_S1TY] = sty[i];
      issue(w, 16'h0000);
      result(sd[i], 16'h0000);
      chk("wb_valid", 32'h0000_0001, {31'h0, wv});
      chk("sat", 32'h0000_0001, {31'h0, os});
      chk("wb_data", se[i], wbd);
    end
    w = base();
    w[`SDX_F_CMOD] = `SDX_CM_NE;
    issue(w, 16'h0000);
    result(32'h0000_0000, 16'hFF0F);
    rreg(`SDX_A_FLAG0, v);
    chk("flag0", 32'h0000_00F0, v);
    $display("test results finished");
    w = base();
    w[`SDX_F_OPC] = `SDX_OP_MUL;
    w[`SDX_F_CMPT] = 1'b1;
    w[`SDX_C_DREG] = 7'h05;
    w[`SDX_C_S0REG] = 7'h06;
    w[`SDX_C_S1REG] = 7'h07;
    w[`SDX_C_TY] = SDX_T_UD;
    // The upper half of a compact word is junk that must be ignored.
    w[127:64] = 64'h0F0F_0F0F_0F0F_0F0F;
    issue(w, 16'h0000);
    ck(2'b10, 16'h00FF);
    chk("dst", 32'h0000_00A0, {20'h0, dst});
    chk("src1", 32'h0000_00E0, {20'h0, s1});
    chk("opcode", 32'h0000_0041, {25'h0, opc});
    wreg(`SDX_A_KLIMIT, 32'h0000_0200);
    issue(base(), 16'h0200);
    ck(2'b00, 16'h0000);
    issue(base(), 16'h01F0);
    ck(2'b10, 16'h00FF);
    w = base();
    w[`SDX_F_OPC] = `SDX_OP_JMP;
    w[`SDX_F_S0RF] = SDX_RF_IMM;
    w[`SDX_F_IMM] = 32'hFFFF_FFE0;
    issue(w, 16'h0100);
    @(posedge clk_i);
    #1;
    chk("fetch", 32'h0000_00E0, {16'h0, fo});
    w[`SDX_F_OPC] = `SDX_OP_MOV;
    w[`SDX_F_DRF] = SDX_RF_ARF;
    w[`SDX_F_DREG] = `SDX_IP_REG;
    w[`SDX_F_IMM] = 32'h0000_0040;
    issue(w, 16'h00E0);
    @(posedge clk_i);
    #1;
    chk("fetch", 32'h0000_0040, {16'h0, fo});
    wreg(`SDX_A_IP, 32'h0000_0300);
    @(posedge clk_i);
    #1;
    chk("fetch", 32'h0000_0300, {16'h0, fo});
    wreg(`SDX_A_FLAG0, 32'h0000_000F);
    w = base();
    w[`SDX_F_OPC] = `SDX_OP_JMP;
    w[`SDX_F_S0RF] = SDX_RF_IMM;
    w[`SDX_F_PRED] = 2'h1;
    w[`SDX_F_IMM] = 32'h0000_0020;
    issue(w, 16'h0100);
    set_ip = 1'b0;
    issue(base(), 16'h0110);
    ck(2'b10, 16'h00F0);
    rreg(`SDX_A_STATUS, v);
    chk("status", 32'h0001_0007, v);
    $display("test flow finished");
    complete_run();
  end
endmodule : sdx_issue_decode_tb
`default_nettype wire
